/* File: ass_pkg.sv */
// Offsets, field positions and reset values of the alert status summary block
package ass_pkg;
    localparam logic [7:0]  LINK_FAULT_STATUS_ADDR    = 8'h03;
    localparam logic [7:0]  PRIMARY_ALERT_STATUS_ADDR = 8'h02;
    localparam logic [7:0]  LINK_CONFIG_ADDR          = 8'h10;
    // Primary alert status fields
    localparam int          PAS_PKT_CHECK_BIT         = 5;
    localparam int          PAS_INTERFACE_BIT         = 4;
    localparam int          PAS_CAL_BIT               = 3;
    localparam int          PAS_BAL_BIT               = 2;
    localparam int          PAS_FG2_BIT               = 1;
    localparam int          PAS_FG1_BIT               = 0;
    // Link fault status fields
    localparam int          LFS_UP_PEC_BIT            = 15;
    localparam int          LFS_DN_PEC_BIT            = 14;
    localparam int          LFS_UP_LINE_BIT           = 13;
    localparam int          LFS_DN_LINE_BIT           = 12;
    localparam int          LFS_UP_PAR_BIT            = 11;
    localparam int          LFS_DN_PAR_BIT            = 10;
    localparam int          LFS_DUAL_BIT              = 9;
    localparam int          LFS_SPI_BIT               = 7;
    localparam int          LFS_SCLK_BIT              = 6;
    localparam int          LFS_OSC3_BIT              = 5;
    localparam int          LFS_INTBUS_BIT            = 4;
    localparam int          LFS_FIXED_ONE_BIT         = 3;
    localparam int          LFS_TWO_WIRE_BIT          = 2;
    localparam int          LFS_REJECT_BIT            = 0;
    localparam logic [15:0] LFS_RESET                 = 16'h0008;
    localparam logic [15:0] LFS_W0C_MASK              = 16'hFE01;
    localparam logic [15:0] LFS_RW_MASK               = 16'h00F0;
    // Link configuration values
    localparam logic [1:0]  LINK_CFG_DUAL             = 2'h3;
    localparam logic [1:0]  LINK_CFG_RESET            = 2'h0;
    // Balancing activity state
    localparam logic [1:0]  BAL_STATE_IDLE            = 2'h0;
    localparam logic [1:0]  BAL_STATE_RUN             = 2'h1;
    localparam logic [1:0]  BAL_STATE_CAL_ABORT       = 2'h3;
    localparam int          CAL_ALERT_COUNT           = 5;
    localparam int          BAL_ALERT_COUNT           = 5;
    localparam int          BAL_CAL_IDX               = 2;
endpackage

/* File: ass_sync.sv */
// Two-flop synchroniser bank for pin-level event inputs
`timescale 1ns/1ps
module ass_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

/* File: ass_alert_status.sv */
// Alert summary and link fault status registers
`timescale 1ns/1ps
// Behaviour
// - packet-check summary never sets interface summary
// - interface errors readable, clearable individually except two-wire bit 2, which follows its pin
// - calibration summary ORs enabled calibration alerts
// - calibration summary read-only, follows components
// - cal error in balancing aborts, state 11
// - balancing summary ORs enabled balancing alerts
// - balancing summary read-only, follows components
// - bit 1 ORs failure group two
// - bit 0 ORs failure group one
// - link fault status at address 0x3
// - upstream packet-check error sets bit 15
// - downstream packet-check error sets bit 14
// - upstream line-code violation sets bit 13
// - downstream line-code violation sets bit 12
// - alert bits clear only by writing 0, except two-wire bit 2, which follows its pin
// - downstream alerts only in dual-link mode
// - interface summary ORs interface error alerts
// - packet-check summary ORs both directions
// - parity errors set bits 11 and 10
// - dual-link fault sets bit 9
module ass_alert_status
    import ass_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        up_pec_err,
    input  wire logic        dn_pec_err,
    input  wire logic        up_line_code_err,
    input  wire logic        dn_line_code_err,
    input  wire logic        up_parity_err,
    input  wire logic        dn_parity_err,
    input  wire logic        dual_link_fault_err,
    input  wire logic        rejected_cmd_err,
    input  wire logic        two_wire_ctrl_err,
    input  wire logic [15:0] failure_group1_conditions,
    input  wire logic [15:0] failure_group2_conditions,
    input  wire logic [4:0]  cal_alerts,
    input  wire logic [4:0]  cal_alert_enable,
    input  wire logic [4:0]  bal_alerts,
    input  wire logic [4:0]  bal_alert_enable,
    input  wire logic        bal_start,
    input  wire logic        bal_finish,
    output logic [1:0]       balancing_active_state,
    output logic             balancing_cal_abort_alert,
    output logic             up_pec_discard,
    output logic             dn_pec_discard,
    output logic [15:0]      primary_alert_status,
    output logic [15:0]      link_fault_status,
    output logic [1:0]       link_config_field
);
    localparam int EVT_W = 9;

    logic [EVT_W-1:0] evt_sync;
    logic             up_pec_s;
    logic             dn_pec_s;
    logic             up_line_s;
    logic             dn_line_s;
    logic             up_par_s;
    logic             dn_par_s;
    logic             dual_s;
    logic             reject_s;
    logic             two_wire_s;
    logic             dual_mode;
    logic             lfs_wr;
    logic [15:0]      lfs_set;
    logic [15:0]      lfs_next;
    logic             cal_any;
    logic             cal_abort_evt;
    logic [4:0]       bal_alert_eff;
    logic [15:0]      pas_next;
    logic             iface_any;

    // Pin events come from the link receivers outside this clock
    ass_sync #(
        .WIDTH(EVT_W)
    ) u_evt_sync (
        .core_clk(core_clk),
        .rst_n   (rst_n),
        .async_in({up_pec_err, dn_pec_err, up_line_code_err, dn_line_code_err,
                   up_parity_err, dn_parity_err, dual_link_fault_err,
                   rejected_cmd_err, two_wire_ctrl_err}),
        .sync_out(evt_sync)
    );

    assign {up_pec_s, dn_pec_s, up_line_s, dn_line_s, up_par_s, dn_par_s,
            dual_s, reject_s, two_wire_s} = evt_sync;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    assign dual_mode = (link_config_field == LINK_CFG_DUAL);
    assign lfs_wr    = reg_wr_en && addr_hit(reg_addr, LINK_FAULT_STATUS_ADDR);

    // Hardware set sources of the link fault bits
    always_comb begin
        lfs_set                   = '0;
        lfs_set[LFS_UP_PEC_BIT]   = up_pec_s;
        lfs_set[LFS_DN_PEC_BIT]   = dn_pec_s && dual_mode;
        lfs_set[LFS_UP_LINE_BIT]  = up_line_s;
        lfs_set[LFS_DN_LINE_BIT]  = dn_line_s && dual_mode;
        lfs_set[LFS_UP_PAR_BIT]   = up_par_s;
        lfs_set[LFS_DN_PAR_BIT]   = dn_par_s && dual_mode;
        lfs_set[LFS_DUAL_BIT]     = dual_s && dual_mode;
        lfs_set[LFS_REJECT_BIT]   = reject_s;
    end

    // Write-0-to-clear bits, set wins over clear; plain bits take the write
    always_comb begin
        lfs_next = link_fault_status;
        if (lfs_wr) begin
            lfs_next = (link_fault_status & ~LFS_W0C_MASK)
                     | (link_fault_status & reg_wdata & LFS_W0C_MASK);
            lfs_next = (lfs_next & ~LFS_RW_MASK) | (reg_wdata & LFS_RW_MASK);
        end
        lfs_next                    = lfs_next | lfs_set;
        lfs_next[LFS_TWO_WIRE_BIT]  = two_wire_s;
        lfs_next[LFS_FIXED_ONE_BIT] = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_fault_status <= LFS_RESET;
        end else begin
            link_fault_status <= lfs_next;
        end
    end

    // Link configuration register selects dual-link checking
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_config_field <= LINK_CFG_RESET;
        end else if (reg_wr_en && addr_hit(reg_addr, LINK_CONFIG_ADDR)) begin
            link_config_field <= reg_wdata[1:0];
        end
    end

    // Packet-check failures discard the received item
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_pec_discard <= 1'b0;
            dn_pec_discard <= 1'b0;
        end else begin
            up_pec_discard <= up_pec_s;
            dn_pec_discard <= dn_pec_s && dual_mode;
        end
    end

    assign cal_any       = |(cal_alerts & cal_alert_enable);
    assign cal_abort_evt = cal_any && (balancing_active_state == BAL_STATE_RUN);

    // Balancing activity: calibration fault aborts a running operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            balancing_active_state <= BAL_STATE_IDLE;
        end else if (cal_abort_evt) begin
            balancing_active_state <= BAL_STATE_CAL_ABORT;
        end else if (bal_start) begin
            balancing_active_state <= BAL_STATE_RUN;
        end else if (bal_finish && balancing_active_state == BAL_STATE_RUN) begin
            balancing_active_state <= BAL_STATE_IDLE;
        end
    end

    // Abort alert holds until a new operation starts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            balancing_cal_abort_alert <= 1'b0;
        end else if (cal_abort_evt) begin
            balancing_cal_abort_alert <= 1'b1;
        end else if (bal_start) begin
            balancing_cal_abort_alert <= 1'b0;
        end
    end

    always_comb begin
        bal_alert_eff              = bal_alerts;
        bal_alert_eff[BAL_CAL_IDX] = bal_alerts[BAL_CAL_IDX] | balancing_cal_abort_alert;
    end

    assign iface_any = |{link_fault_status[LFS_UP_LINE_BIT], link_fault_status[LFS_DN_LINE_BIT],
                         link_fault_status[LFS_UP_PAR_BIT], link_fault_status[LFS_DN_PAR_BIT],
                         link_fault_status[LFS_DUAL_BIT], link_fault_status[LFS_REJECT_BIT],
                         link_fault_status[LFS_TWO_WIRE_BIT]};

    // Read-only summaries recomputed each cycle, writes have no effect
    always_comb begin
        pas_next                    = '0;
        pas_next[PAS_PKT_CHECK_BIT] = link_fault_status[LFS_UP_PEC_BIT]
                                    | link_fault_status[LFS_DN_PEC_BIT];
        pas_next[PAS_INTERFACE_BIT] = iface_any;
        pas_next[PAS_CAL_BIT]       = cal_any;
        pas_next[PAS_BAL_BIT]       = |(bal_alert_eff & bal_alert_enable);
        pas_next[PAS_FG2_BIT]       = |failure_group2_conditions;
        pas_next[PAS_FG1_BIT]       = |failure_group1_conditions;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_alert_status <= '0;
        end else begin
            primary_alert_status <= pas_next;
        end
    end

    // Registered read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd_en) begin
            if (addr_hit(reg_addr, LINK_FAULT_STATUS_ADDR)) begin
                reg_rdata <= link_fault_status;
            end else if (addr_hit(reg_addr, PRIMARY_ALERT_STATUS_ADDR)) begin
                reg_rdata <= primary_alert_status;
            end else if (addr_hit(reg_addr, LINK_CONFIG_ADDR)) begin
                reg_rdata <= {14'h0000, link_config_field};
            end else begin
                reg_rdata <= '0;
            end
        end
    end
endmodule

/* File: ass_alert_status_sva.sv */
// Concurrent checks on the alert status block ports
`timescale 1ns/1ps
module ass_alert_status_sva
    import ass_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        up_pec_err,
    input wire logic        dn_pec_err,
    input wire logic        two_wire_ctrl_err,
    input wire logic [15:0] failure_group1_conditions,
    input wire logic [15:0] failure_group2_conditions,
    input wire logic [4:0]  cal_alerts,
    input wire logic [4:0]  cal_alert_enable,
    input wire logic [1:0]  balancing_active_state,
    input wire logic        balancing_cal_abort_alert,
    input wire logic        up_pec_discard,
    input wire logic        dn_pec_discard,
    input wire logic [15:0] primary_alert_status,
    input wire logic [15:0] link_fault_status,
    input wire logic [1:0]  link_config_field
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_up_evt;
        up_pec_err [*2];
    endsequence
    sequence s_dn_evt;
        dn_pec_err [*2];
    endsequence
    sequence s_lfs_wr;
        reg_wr_en && reg_addr == LINK_FAULT_STATUS_ADDR;
    endsequence
    a_cal_sum: assert property (1 |=> primary_alert_status[3] ==
        $past(|(cal_alerts & cal_alert_enable))) else $error("cal summary wrong");
    a_fail_or: assert property (1 |=> primary_alert_status[1:0] ==
        {$past(|failure_group2_conditions), $past(|failure_group1_conditions)})
        else $error("failure summary wrong");
    a_pec_sum: assert property (1 |=> primary_alert_status[5] ==
        $past(link_fault_status[15] | link_fault_status[14])) else $error("pec sum wrong");
    a_iface_sum: assert property (1 |=> primary_alert_status[4] ==
        $past(|{link_fault_status[13:9], link_fault_status[2], link_fault_status[0]}))
        else $error("interface summary wrong");
    a_write_one_keeps: assert property (s_lfs_wr |=>
        (link_fault_status & $past(link_fault_status & reg_wdata & LFS_W0C_MASK))
        == $past(link_fault_status & reg_wdata & LFS_W0C_MASK)) else $error("w1 lost bit");
    a_up_pec_set: assert property (s_up_evt |-> ##2 link_fault_status[15]
        && up_pec_discard) else $error("up pec not flagged");
    a_down_gated: assert property ($rose(link_fault_status[14]) |->
        link_config_field == LINK_CFG_DUAL) else $error("down alert outside dual");
    a_abort_state: assert property ($rose(balancing_cal_abort_alert) |->
        balancing_active_state == BAL_STATE_CAL_ABORT) else $error("abort state wrong");
    a_read_back: assert property (reg_rd_en && reg_addr == LINK_FAULT_STATUS_ADDR
        |=> reg_rdata == $past(link_fault_status)) else $error("read data wrong");
    a_dn_discard: assert property (s_dn_evt |-> ##2
        dn_pec_discard == (link_config_field == LINK_CFG_DUAL)) else $error("down discard wrong");
    a_two_wire_mirror: assert property (1 |-> link_fault_status[2] ==
        $past(two_wire_ctrl_err, 3)) else $error("two wire bit wrong");
endmodule

bind ass_alert_status ass_alert_status_sva u_sva (.*);

/* File: tb.sv */
// Self-checking bench for the alert status block
`timescale 1ns/1ps
module tb;
    import ass_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, primary_alert_status, link_fault_status;
    logic [15:0] failure_group1_conditions = 16'h0000, failure_group2_conditions = 16'h0000;
    wire         up_pec_err, dn_pec_err, up_line_code_err, dn_line_code_err, up_parity_err;
    wire         dn_parity_err, dual_link_fault_err, rejected_cmd_err, two_wire_ctrl_err;
    logic [8:0]  ev = 9'h000;
    logic [4:0]  cal_alerts = 5'h00, cal_alert_enable = 5'h00, bal_alerts = 5'h00;
    logic [4:0]  bal_alert_enable = 5'h00;
    logic        bal_start = 1'b0, bal_finish = 1'b0, balancing_cal_abort_alert;
    logic        up_pec_discard, dn_pec_discard;
    logic [1:0]  balancing_active_state, link_config_field;
    logic [15:0] m_lfs = 16'h0008, r = 16'h0024;
    int          n_errors = 0, samples_checked = 0;
    assign {up_pec_err, dn_pec_err, up_line_code_err, dn_line_code_err, up_parity_err,
            dn_parity_err, dual_link_fault_err, rejected_cmd_err, two_wire_ctrl_err} = ev;
    ass_alert_status dut (.*);
    always #50 core_clk = ~core_clk;
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [15:0] wmod(logic [15:0] m, logic [15:0] d);
        return ((m & (~LFS_W0C_MASK | d)) & ~LFS_RW_MASK) | (d & LFS_RW_MASK);
    endfunction
    function automatic logic [15:0] prim();
        return {10'h000, m_lfs[15] | m_lfs[14], |{m_lfs[13:9], m_lfs[2], m_lfs[0]},
                |(cal_alerts & cal_alert_enable), |(bal_alerts & bal_alert_enable),
                |failure_group2_conditions, |failure_group1_conditions};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (e !== g) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge core_clk);
        reg_wr_en <= w;
        reg_rd_en <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        #1;
    endtask
    task automatic ev_pulse(logic [8:0] v);
        @(posedge core_clk);
        ev <= v;
        cyc(2);
        ev <= 9'h000;
        cyc(5);
    endtask
    task automatic one_pulse(int sel);
        @(posedge core_clk);
        if (sel == 0) bal_start <= 1'b1;
        else bal_finish <= 1'b1;
        @(posedge core_clk);
        bal_start  <= 1'b0;
        bal_finish <= 1'b0;
        cyc(3);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        cyc(3);
        rst_n <= 1'b1;
        acc(0, LINK_FAULT_STATUS_ADDR, 16'h0000);
        chk("link fault", LFS_RESET, reg_rdata);
        acc(0, 8'h40, 16'h0000);
        chk("unmapped", 16'h0000, reg_rdata);
        acc(1, LINK_CONFIG_ADDR, 16'h0003);
        chk("config", LINK_CFG_DUAL, link_config_field);
        for (int i = 1; i < 9; i++) begin
            ev_pulse(9'h001 << i);
            m_lfs[i == 1 ? 0 : i + 7] = 1'b1;
            chk("link fault", m_lfs, link_fault_status);
            chk("primary", prim(), primary_alert_status);
        end
        for (int i = 0; i < 10; i++) begin
            r = lfsr(r);
            acc(1, i == 0 ? LINK_FAULT_STATUS_ADDR : (r[0] ? 8'h03 : 8'h02), i == 0 ? 16'hFFFF : r);
            if (i == 0 || r[0]) m_lfs = wmod(m_lfs, i == 0 ? 16'hFFFF : r);
            cyc(2);
            acc(0, LINK_FAULT_STATUS_ADDR, 16'h0000);
            chk("link fault", m_lfs, reg_rdata);
            acc(0, PRIMARY_ALERT_STATUS_ADDR, 16'h0000);
            chk("primary", prim(), reg_rdata);
        end
        acc(1, LINK_FAULT_STATUS_ADDR, 16'h0000);
        acc(1, LINK_CONFIG_ADDR, 16'h0000);
        m_lfs = LFS_RESET;
        @(posedge core_clk);
        ev <= 9'h001;
        m_lfs[LFS_TWO_WIRE_BIT] = 1'b1;
        cyc(5);
        chk("link fault", m_lfs, link_fault_status);
        chk("primary", prim(), primary_alert_status);
        ev <= 9'h000;
        m_lfs[LFS_TWO_WIRE_BIT] = 1'b0;
        cyc(5);
        ev_pulse(9'h0AC);
        chk("link fault", m_lfs, link_fault_status);
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            @(posedge core_clk);
            failure_group1_conditions <= r[1] ? r : 16'h0000;
            failure_group2_conditions <= r[2] ? lfsr(r) : 16'h0000;
            {cal_alerts, cal_alert_enable, bal_alerts} <= r[14:0];
            bal_alert_enable <= 5'(lfsr(r) & 16'h001B);
            cyc(3);
            chk("primary", prim(), primary_alert_status);
        end
        @(posedge core_clk);
        {cal_alerts, bal_alerts} <= 10'h000;
        one_pulse(0);
        chk("bal state", BAL_STATE_RUN, balancing_active_state);
        cal_alerts       <= 5'h01;
        cal_alert_enable <= 5'h01;
        bal_alert_enable <= 5'h04;
        cyc(4);
        chk("bal state", BAL_STATE_CAL_ABORT, balancing_active_state);
        chk("abort", 16'h0001, balancing_cal_abort_alert);
        chk("bal sum", 16'h0001, primary_alert_status[2]);
        cal_alerts <= 5'h00;
        one_pulse(0);
        chk("abort", 16'h0000, balancing_cal_abort_alert);
        one_pulse(1);
        chk("bal state", BAL_STATE_IDLE, balancing_active_state);
        wrap_up();
    end
    initial begin
        cyc(3000);
        n_errors++;
        wrap_up();
    end
endmodule
